/* File: hdl/hs_compare_pkg.sv */
// Constants, register map and types for the high-speed compare block
package hs_compare_pkg;

  localparam int CNT_W = 32;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 10;
  localparam int TAB_MAX = 128;
  localparam int IDX_W = 7;
  localparam int TAB_AW = 9;
  localparam int MAX_ACTIVE = 6;
  localparam int N_OUT = 16;
  localparam int EXT_W = 3;

  // Register word addresses
  localparam logic [ADDR_W-1:0] A_CTRL = 10'h000;
  localparam logic [ADDR_W-1:0] A_PRESET = 10'h001;
  localparam logic [ADDR_W-1:0] A_ZONE_LOW = 10'h002;
  localparam logic [ADDR_W-1:0] A_ZONE_HIGH = 10'h003;
  localparam logic [ADDR_W-1:0] A_COUNT = 10'h004;
  localparam logic [ADDR_W-1:0] A_TAB_LEN = 10'h005;
  localparam logic [ADDR_W-1:0] A_STATUS = 10'h006;
  localparam logic [ADDR_W-1:0] A_REC_INDEX = 10'h007;
  localparam logic [ADDR_W-1:0] A_REC_VALUE = 10'h008;
  localparam logic [ADDR_W-1:0] A_PARAM = 10'h009;
  localparam int TAB_SEL_BIT = 9;

  // Control bits
  localparam int C_DRIVE = 0;
  localparam int C_ZONE = 1;
  localparam int C_OUT_TAB = 2;
  localparam int C_PAR_TAB = 3;
  localparam int C_DIR = 4;
  localparam int C_UPDOWN = 5;
  localparam int CTRL_W = 6;

  // Status bits
  localparam int S_CONTACT = 0;
  localparam int S_DIR = 1;
  localparam int S_WRAP = 2;
  localparam int S_ZONE_LSB = 3;
  localparam int S_HALT = 6;
  localparam int S_OWN_LSB = 7;
  localparam int S_ZONE_ON = 9;
  localparam int S_TAB_ON = 10;

  localparam logic [2:0] ZONE_NONE = 3'h0;
  localparam logic [2:0] ZONE_BELOW = 3'h1;
  localparam logic [2:0] ZONE_INSIDE = 3'h2;
  localparam logic [2:0] ZONE_ABOVE = 3'h4;
  localparam logic [7:0] TAB_LEN_RST = 8'h01;

  typedef enum logic [1:0] {OWN_NONE, OWN_OUT, OWN_PARAM} owner_type;

endpackage : hs_compare_pkg

/* File: hdl/pin_edge_sync.sv */
// Two-stage pin synchroniser with rising-edge detect per bit
`timescale 1ns/1ps
module pin_edge_sync #(
  parameter int N = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [N-1:0] i_pin,
  output logic [N-1:0] o_level,
  output logic [N-1:0] o_rise
);

  logic [N-1:0] meta;
  logic [N-1:0] prev;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
          meta[g] <= 1'b0;
          o_level[g] <= 1'b0;
          prev[g] <= 1'b0;
        end else if (i_clk_en) begin
          meta[g] <= i_pin[g];
          o_level[g] <= meta[g];
          prev[g] <= o_level[g];
        end
      end
      // Edge taken from the second stage only, never from meta
      assign o_rise[g] = o_level[g] & ~prev[g];
    end
  endgenerate

endmodule : pin_edge_sync

/* File: hdl/hs_counter_zone_table_compare.sv */
// High-speed counter with zone, output-table and parameter-table compare
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module hs_counter_zone_table_compare #(
  parameter int N_OUT = hs_compare_pkg::N_OUT,
  parameter int MAX_ACTIVE = hs_compare_pkg::MAX_ACTIVE
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [hs_compare_pkg::ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_start_pin,
  input wire logic i_clear_pin,
  input wire logic i_up_pin,
  input wire logic i_down_pin,
  input wire logic [hs_compare_pkg::EXT_W-1:0] i_ext_active,
  output logic [31:0] o_rd_data,
  output logic [2:0] o_zone,
  output logic [N_OUT-1:0] o_table_out,
  output logic [31:0] o_param,
  output logic o_contact
);

  localparam int OUT_W = (N_OUT > 1) ? $clog2(N_OUT) : 1;
  localparam int IW = hs_compare_pkg::IDX_W;

  ////////////////////////////////////////////////////////////////////////////
  // Pins
  logic [3:0] lvl;
  logic [3:0] rise;
  logic lvl_start, lvl_clear, rise_up, rise_dn;

  pin_edge_sync #(.N(4)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_pin({i_down_pin, i_up_pin, i_clear_pin, i_start_pin}),
    .o_level(lvl),
    .o_rise(rise)
  );
  assign lvl_start = lvl[0];
  assign lvl_clear = lvl[1];
  assign rise_up = rise[2];
  assign rise_dn = rise[3];

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [hs_compare_pkg::CTRL_W-1:0] ctrl;
  logic [31:0] preset, zone_low, zone_high;
  logic [7:0] tab_len;
  logic [hs_compare_pkg::WORD_W-1:0] tab [2**hs_compare_pkg::TAB_AW];
  logic drive_en, dir_bit, updown;
  logic wr_ctrl, wr_count, wr_status, wr_tab;

  assign drive_en = ctrl[hs_compare_pkg::C_DRIVE];
  assign dir_bit = ctrl[hs_compare_pkg::C_DIR];
  assign updown = ctrl[hs_compare_pkg::C_UPDOWN];
  assign wr_tab = i_wr && i_addr[hs_compare_pkg::TAB_SEL_BIT];
  assign wr_ctrl = i_wr && i_addr == hs_compare_pkg::A_CTRL;
  assign wr_count = i_wr && i_addr == hs_compare_pkg::A_COUNT;
  assign wr_status = i_wr && i_addr == hs_compare_pkg::A_STATUS;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ctrl <= '0;
      preset <= '0;
      zone_low <= '0;
      zone_high <= '0;
      tab_len <= hs_compare_pkg::TAB_LEN_RST;
    end else if (i_clk_en && i_wr) begin
      case (i_addr)
        hs_compare_pkg::A_CTRL:
          ctrl <= i_wr_data[hs_compare_pkg::CTRL_W-1:0];
        hs_compare_pkg::A_PRESET: preset <= i_wr_data;
        hs_compare_pkg::A_ZONE_LOW: zone_low <= i_wr_data;
        hs_compare_pkg::A_ZONE_HIGH: zone_high <= i_wr_data;
        hs_compare_pkg::A_TAB_LEN: tab_len <= i_wr_data[7:0];
        default: ;
      endcase
    end
  end

  // Table words have no reset; software loads them before enabling
  always_ff @(posedge i_clk_sys) begin
    if (i_clk_en && wr_tab) begin
      tab[i_addr[hs_compare_pkg::TAB_AW-1:0]] <=
        i_wr_data[hs_compare_pkg::WORD_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter
  logic [31:0] count, next_count;
  logic inc, dec, step, step_q, clr_act, dir_status;

  always_comb begin
    inc = 1'b0;
    dec = 1'b0;
    if (drive_en && lvl_start && !lvl_clear) begin
      if (updown) begin
        // Coincident up and down pulses cancel
        inc = rise_up & ~rise_dn;
        dec = rise_dn & ~rise_up;
      end else begin
        inc = rise_up & ~dir_bit;
        dec = rise_up & dir_bit;
      end
    end
  end
  assign step = inc | dec;
  assign next_count = inc ? count + 32'h1 : count - 32'h1;
  assign clr_act = drive_en && lvl_clear;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      count <= '0;
      step_q <= 1'b0;
    end else if (i_clk_en) begin
      step_q <= step;
      if (clr_act) begin
        count <= '0;
      end else if (step) begin
        count <= next_count;
      end else if (wr_count) begin
        count <= i_wr_data;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_contact <= 1'b0;
    end else if (i_clk_en) begin
      if (clr_act) begin
        o_contact <= 1'b0;
      end else if (step && next_count == preset) begin
        if (count == preset - 32'h1) begin
          o_contact <= 1'b1;
        end else if (count == preset + 32'h1) begin
          o_contact <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      dir_status <= 1'b0;
    end else if (i_clk_en && updown) begin
      if (inc) begin
        dir_status <= 1'b0;
      end else if (dec) begin
        dir_status <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot grant and table ownership
  hs_compare_pkg::owner_type owner;
  logic halted, zone_on, out_on, par_on;
  logic [3:0] used;

  // Other compare functions ahead of this block take the first slots
  assign zone_on = ctrl[hs_compare_pkg::C_ZONE] && drive_en &&
                   (i_ext_active < MAX_ACTIVE);
  assign used = {1'b0, i_ext_active} + {3'h0, zone_on};
  assign out_on = owner == hs_compare_pkg::OWN_OUT && drive_en &&
                  (used < MAX_ACTIVE);
  assign par_on = owner == hs_compare_pkg::OWN_PARAM && drive_en &&
                  !halted && (used < MAX_ACTIVE);

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      owner <= hs_compare_pkg::OWN_NONE;
    end else if (i_clk_en) begin
      case (owner)
        hs_compare_pkg::OWN_NONE: begin
          if (ctrl[hs_compare_pkg::C_OUT_TAB]) begin
            owner <= hs_compare_pkg::OWN_OUT;
          end else if (ctrl[hs_compare_pkg::C_PAR_TAB]) begin
            owner <= hs_compare_pkg::OWN_PARAM;
          end
        end
        hs_compare_pkg::OWN_OUT: begin
          if (!ctrl[hs_compare_pkg::C_OUT_TAB]) begin
            owner <= hs_compare_pkg::OWN_NONE;
          end
        end
        hs_compare_pkg::OWN_PARAM: begin
          if (!ctrl[hs_compare_pkg::C_PAR_TAB]) begin
            owner <= hs_compare_pkg::OWN_NONE;
          end
        end
        default: owner <= hs_compare_pkg::OWN_NONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zone compare, evaluated on the cycle after a pulse step only
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_zone <= hs_compare_pkg::ZONE_NONE;
    end else if (i_clk_en && step_q && zone_on) begin
      if ($signed(count) < $signed(zone_low)) begin
        o_zone <= hs_compare_pkg::ZONE_BELOW;
      end else if ($signed(count) <= $signed(zone_high)) begin
        o_zone <= hs_compare_pkg::ZONE_INSIDE;
      end else begin
        o_zone <= hs_compare_pkg::ZONE_ABOVE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table compare
  logic [IW-1:0] idx, last_idx;
  logic [31:0] rec_value, rec_w23;
  logic [hs_compare_pkg::WORD_W-1:0] rec_tgt;
  logic match, is_last, halt_now, wrap_flag;

  // Record layout: value high, value low, target or high, state or low
  assign rec_value = {tab[{idx, 2'h0}], tab[{idx, 2'h1}]};
  assign rec_tgt = tab[{idx, 2'h2}];
  assign rec_w23 = {rec_tgt, tab[{idx, 2'h3}]};
  // Out-of-range lengths are clamped rather than trusted
  assign last_idx = (tab_len == 8'h00) ? '0 :
                    (tab_len > 8'h80) ? '1 : IW'(tab_len - 8'h01);
  assign is_last = idx == last_idx;
  assign match = step_q && (out_on || par_on) &&
                 count == rec_value;
  assign halt_now = par_on && is_last && rec_w23 == 32'h0;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      idx <= '0;
      halted <= 1'b0;
    end else if (i_clk_en) begin
      if (owner == hs_compare_pkg::OWN_NONE) begin
        idx <= '0;
        halted <= 1'b0;
      end else if (match) begin
        if (halt_now) begin
          halted <= 1'b1;
        end else begin
          idx <= is_last ? '0 : idx + 7'h01;
        end
      end
    end
  end

  // Wrap flag: hardware set wins over a same-cycle write-one clear
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      wrap_flag <= 1'b0;
    end else if (i_clk_en) begin
      if (match && is_last && !halt_now) begin
        wrap_flag <= 1'b1;
      end else if (wr_status && i_wr_data[hs_compare_pkg::S_WRAP]) begin
        wrap_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_table_out <= '0;
    end else if (i_clk_en && match && out_on && rec_tgt < N_OUT) begin
      o_table_out[rec_tgt[OUT_W-1:0]] <= tab[{idx, 2'h3}][0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_param <= '0;
    end else if (i_clk_en && match && par_on) begin
      o_param <= rec_w23;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  logic [31:0] status;

  always_comb begin
    status = '0;
    status[hs_compare_pkg::S_CONTACT] = o_contact;
    status[hs_compare_pkg::S_DIR] = dir_status;
    status[hs_compare_pkg::S_WRAP] = wrap_flag;
    status[hs_compare_pkg::S_ZONE_LSB +: 3] = o_zone;
    status[hs_compare_pkg::S_HALT] = halted;
    status[hs_compare_pkg::S_OWN_LSB +: 2] = owner;
    status[hs_compare_pkg::S_ZONE_ON] = zone_on;
    status[hs_compare_pkg::S_TAB_ON] = out_on | par_on;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_rd_data <= '0;
    end else if (i_clk_en) begin
      o_rd_data <= '0;
      if (i_rd && i_addr[hs_compare_pkg::TAB_SEL_BIT]) begin
        o_rd_data[hs_compare_pkg::WORD_W-1:0] <=
          tab[i_addr[hs_compare_pkg::TAB_AW-1:0]];
      end else if (i_rd) begin
        case (i_addr)
          hs_compare_pkg::A_CTRL:
            o_rd_data[hs_compare_pkg::CTRL_W-1:0] <= ctrl;
          hs_compare_pkg::A_PRESET: o_rd_data <= preset;
          hs_compare_pkg::A_ZONE_LOW: o_rd_data <= zone_low;
          hs_compare_pkg::A_ZONE_HIGH: o_rd_data <= zone_high;
          hs_compare_pkg::A_COUNT: o_rd_data <= count;
          hs_compare_pkg::A_TAB_LEN: o_rd_data[7:0] <= tab_len;
          hs_compare_pkg::A_STATUS: o_rd_data <= status;
          hs_compare_pkg::A_REC_INDEX: o_rd_data[IW-1:0] <= idx;
          hs_compare_pkg::A_REC_VALUE: o_rd_data <= rec_value;
          hs_compare_pkg::A_PARAM: o_rd_data <= o_param;
          default: o_rd_data <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  chk_zone_below: assert property (
    i_clk_en && step_q && zone_on && $signed(count) < $signed(zone_low)
    |=> o_zone == hs_compare_pkg::ZONE_BELOW)
    else $error("zone below bound not flagged");
  chk_zone_inside: assert property (
    i_clk_en && step_q && zone_on && $signed(count) >= $signed(zone_low)
    && $signed(count) <= $signed(zone_high)
    |=> o_zone == hs_compare_pkg::ZONE_INSIDE)
    else $error("zone inside bounds not flagged");
  chk_zone_above: assert property (
    i_clk_en && step_q && zone_on && $signed(count) > $signed(zone_high)
    |=> o_zone == hs_compare_pkg::ZONE_ABOVE)
    else $error("zone above bound not flagged");
  chk_zone_one_hot: assert property (
    $past(step_q && zone_on && i_clk_en) |-> $onehot(o_zone))
    else $error("zone outputs not one-hot");
  chk_count_only_steps: assert property (
    i_clk_en && !step && !clr_act && !wr_count |=> $stable(count))
    else $error("counter moved without a cause");
  chk_start_holds: assert property (
    i_clk_en && !lvl_start && !wr_count && !clr_act |=> $stable(count))
    else $error("counter moved while stopped");
  chk_clear_zero: assert property (
    i_clk_en && clr_act |=> count == 32'h0 && !o_contact)
    else $error("clear did not zero counter");
  chk_dir_down: assert property (
    i_clk_en && updown && dec |=> dir_status)
    else $error("down pulse did not set direction");
  chk_contact_set: assert property (
    i_clk_en && !clr_act && step && next_count == preset
    && count == preset - 32'h1 |=> o_contact)
    else $error("contact not set at preset");
  chk_param_copy: assert property (
    i_clk_en && match && par_on |=> o_param == $past(rec_w23))
    else $error("parameter not copied on match");
  chk_wrap_index: assert property (
    i_clk_en && match && is_last && !halt_now
    && owner == $past(owner) |=> idx == '0 && wrap_flag)
    else $error("table did not wrap");
  chk_halt_holds: assert property (
    i_clk_en && halted && owner == hs_compare_pkg::OWN_PARAM
    && ctrl[hs_compare_pkg::C_PAR_TAB] |=> halted && $stable(idx) && !par_on)
    else $error("halted table moved");
  chk_owner_excl: assert property (
    i_clk_en && owner == hs_compare_pkg::OWN_OUT
    && ctrl[hs_compare_pkg::C_OUT_TAB] |=> owner == hs_compare_pkg::OWN_OUT)
    else $error("output table lost ownership");

  cov_zone_inside: cover property (o_zone == hs_compare_pkg::ZONE_INSIDE);
  cov_table_wrap: cover property (match && is_last && out_on);
  cov_param_halt: cover property (match && halt_now);
  cov_contact: cover property ($rose(o_contact));

endmodule : hs_counter_zone_table_compare

/* File: verif/pulse_source.sv */
// Field pulse source standing in for the counting pins of the counter
`timescale 1ns/1ps
module pulse_source (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_fire,
  input wire logic i_down,
  output logic o_up_pin,
  output logic o_down_pin,
  output logic o_busy
);
  logic [3:0] phase;
  logic down;

  ////////////////////////////////////////////////////////////////////////////
  // Two cycles high, then a long low gap so each rise is seen exactly once
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      phase <= 4'h0;
      down <= 1'b0;
    end else if (phase == 4'h0) begin
      if (i_fire) begin
        phase <= 4'h1;
        down <= i_down;
      end
    end else if (phase == 4'ha) begin
      phase <= 4'h0;
    end else begin
      phase <= phase + 4'h1;
    end
  end

  assign o_up_pin = (phase == 4'h1 || phase == 4'h2) && !down;
  assign o_down_pin = (phase == 4'h1 || phase == 4'h2) && down;
  assign o_busy = (phase != 4'h0);
endmodule : pulse_source

/* File: verif/test_hs_counter_zone_table_compare.sv */
// Self-checking bench for the high-speed counter compare block
`timescale 1ns/1ps
module test_hs_counter_zone_table_compare;
  logic clk = 1'b0;
  logic rst, wr, rd, start, clr, fire, dn, ce;
  logic [9:0] addr;
  logic [31:0] wdata, rd_data, param;
  logic [2:0] ext, zone;
  logic [15:0] tab_out;
  logic contact, up_pin, down_pin, busy;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  logic [2:0] zexp [6] = '{3'h1, 3'h2, 3'h2, 3'h2, 3'h2, 3'h4};

  hs_counter_zone_table_compare hs_counter_zone_table_compare_i (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(ce), .i_addr(addr),
    .i_wr_data(wdata), .i_wr(wr), .i_rd(rd), .i_start_pin(start),
    .i_clear_pin(clr), .i_up_pin(up_pin), .i_down_pin(down_pin),
    .i_ext_active(ext), .o_rd_data(rd_data), .o_zone(zone),
    .o_table_out(tab_out), .o_param(param), .o_contact(contact));

  pulse_source pulse_source_i (.i_clk_sys(clk), .i_sys_rst(rst),
    .i_fire(fire), .i_down(dn), .o_up_pin(up_pin), .o_down_pin(down_pin),
    .o_busy(busy));

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // A hang costs a mismatch rather than a silent stall
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wreg(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  // Read data stand only in the cycle after the strobe
  task automatic rdchk(input string name, input logic [9:0] a,
                       input logic [31:0] mask, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(name, exp, rd_data & mask);
  endtask : rdchk

  task automatic wrec(input int rec, input logic [15:0] w0, w1, w2, w3);
    logic [9:0] a;
    a = 10'h200 + 10'(4 * rec);
    wreg(a, {16'h0000, w0});
    wreg(a + 10'h001, {16'h0000, w1});
    wreg(a + 10'h002, {16'h0000, w2});
    wreg(a + 10'h003, {16'h0000, w3});
  endtask : wrec

  // One pin pulse; returns once the partner is idle and outputs settled
  task automatic pulse(input logic d);
    int n;
    @(posedge clk);
    fire <= 1'b1;
    dn <= d;
    @(posedge clk);
    fire <= 1'b0;
    #1;
    for (n = 0; n < 20 && busy !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 20) chk("pulse done", 32'h1, 32'h0);
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; start = 1'b0; clr = 1'b0;
    fire = 1'b0; dn = 1'b0; addr = 10'h000; wdata = 32'h0; ext = 3'h0;
    ce = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdchk("ctrl", hs_compare_pkg::A_CTRL, '1, 32'h0);
    rdchk("tab_len", hs_compare_pkg::A_TAB_LEN, '1, 32'h1);
    wreg(10'h00a, 32'h1234_5678);
    rdchk("unmapped", 10'h00a, '1, 32'h0);
    pulse(1'b0);
    rdchk("count", hs_compare_pkg::A_COUNT, '1, 32'h0);
    wreg(hs_compare_pkg::A_CTRL, 32'h1);
    pulse(1'b0);
    rdchk("count", hs_compare_pkg::A_COUNT, '1, 32'h0);
    @(posedge clk) start <= 1'b1;
    pulse(1'b0);
    rdchk("count", hs_compare_pkg::A_COUNT, '1, 32'h1);
    // A pulse seen while the clock enable is low must be lost entirely
    @(posedge clk) ce <= 1'b0;
    pulse(1'b0);
    @(posedge clk) ce <= 1'b1;
    rdchk("count frozen", hs_compare_pkg::A_COUNT, '1, 32'h1);
    wreg(hs_compare_pkg::A_CTRL, 32'h11);
    pulse(1'b0);
    pulse(1'b0);
    rdchk("count", hs_compare_pkg::A_COUNT, '1, 32'hffff_ffff);
    // Signed bounds around zero catch an unsigned compare
    wreg(hs_compare_pkg::A_ZONE_LOW, 32'hffff_fffe);
    wreg(hs_compare_pkg::A_ZONE_HIGH, 32'h1);
    wreg(hs_compare_pkg::A_CTRL, 32'h3);
    wreg(hs_compare_pkg::A_COUNT, 32'hffff_fffc);
    // Give a wrongly triggered compare time to show up
    repeat (3) @(posedge clk);
    #1;
    chk("zone", 32'h0, 32'(zone));
    for (int i = 0; i < 6; i++) begin
      pulse(1'b0);
      chk("zone", 32'(zexp[i]), 32'(zone));
    end
    wreg(hs_compare_pkg::A_COUNT, 32'h0);
    repeat (3) @(posedge clk);
    #1;
    chk("zone", 32'h4, 32'(zone));
    @(posedge clk) ext <= 3'h6;
    pulse(1'b0);
    chk("zone", 32'h4, 32'(zone));
    rdchk("zone on", hs_compare_pkg::A_STATUS, 32'h200, 32'h0);
    @(posedge clk) ext <= 3'h5;
    wreg(hs_compare_pkg::A_CTRL, 32'h13);
    pulse(1'b0);
    chk("zone", 32'h2, 32'(zone));
    @(posedge clk) ext <= 3'h0;
    // Contact edges in two-input mode
    wreg(hs_compare_pkg::A_PRESET, 32'h5);
    wreg(hs_compare_pkg::A_COUNT, 32'h4);
    wreg(hs_compare_pkg::A_CTRL, 32'h21);
    pulse(1'b0);
    chk("contact", 32'h1, 32'(contact));
    pulse(1'b0);
    chk("contact", 32'h1, 32'(contact));
    pulse(1'b1);
    chk("contact", 32'h0, 32'(contact));
    rdchk("dir", hs_compare_pkg::A_STATUS, 32'h2, 32'h2);
    pulse(1'b0);
    chk("contact", 32'h0, 32'(contact));
    rdchk("dir", hs_compare_pkg::A_STATUS, 32'h2, 32'h0);
    wreg(hs_compare_pkg::A_COUNT, 32'h4);
    pulse(1'b0);
    @(posedge clk) clr <= 1'b1;
    repeat (8) @(posedge clk);
    rdchk("count", hs_compare_pkg::A_COUNT, '1, 32'h0);
    chk("contact", 32'h0, 32'(contact));
    @(posedge clk) clr <= 1'b0;
    // Output table: two records on one target, then wrap
    wrec(0, 16'h0000, 16'h0003, 16'h0004, 16'h0001);
    wrec(1, 16'h0000, 16'h0005, 16'h0004, 16'h0000);
    wreg(hs_compare_pkg::A_TAB_LEN, 32'h2);
    wreg(hs_compare_pkg::A_COUNT, 32'h2);
    wreg(hs_compare_pkg::A_CTRL, 32'h5);
    rdchk("index", hs_compare_pkg::A_REC_INDEX, '1, 32'h0);
    rdchk("value", hs_compare_pkg::A_REC_VALUE, '1, 32'h3);
    pulse(1'b0);
    chk("out", 32'h10, 32'(tab_out));
    rdchk("index", hs_compare_pkg::A_REC_INDEX, '1, 32'h1);
    rdchk("value", hs_compare_pkg::A_REC_VALUE, '1, 32'h5);
    pulse(1'b0);
    chk("out", 32'h10, 32'(tab_out));
    pulse(1'b0);
    chk("out", 32'h0, 32'(tab_out));
    rdchk("wrap", hs_compare_pkg::A_STATUS, 32'h4, 32'h4);
    rdchk("index", hs_compare_pkg::A_REC_INDEX, '1, 32'h0);
    wreg(hs_compare_pkg::A_STATUS, 32'h4);
    rdchk("wrap", hs_compare_pkg::A_STATUS, 32'h4, 32'h0);
    wreg(hs_compare_pkg::A_CTRL, 32'hd);
    rdchk("owner", hs_compare_pkg::A_STATUS, 32'h180, 32'h80);
    wreg(hs_compare_pkg::A_COUNT, 32'h2);
    pulse(1'b0);
    chk("param", 32'h0, param);
    // Parameter table with a zero last record halts there
    wreg(hs_compare_pkg::A_CTRL, 32'h1);
    wreg(hs_compare_pkg::A_CTRL, 32'h9);
    wrec(0, 16'h0000, 16'h0003, 16'h0001, 16'h0002);
    wrec(1, 16'h0000, 16'h0005, 16'h0000, 16'h0000);
    wreg(hs_compare_pkg::A_COUNT, 32'h2);
    pulse(1'b0);
    chk("param", 32'h0001_0002, param);
    rdchk("param", hs_compare_pkg::A_PARAM, '1, 32'h0001_0002);
    pulse(1'b0);
    pulse(1'b0);
    chk("param", 32'h0, param);
    rdchk("halt", hs_compare_pkg::A_STATUS, 32'h5c0, 32'h140);
    wreg(hs_compare_pkg::A_COUNT, 32'h2);
    pulse(1'b0);
    chk("param", 32'h0, param);
    rdchk("index", hs_compare_pkg::A_REC_INDEX, '1, 32'h1);
    wreg(hs_compare_pkg::A_CTRL, 32'hd);
    rdchk("owner", hs_compare_pkg::A_STATUS, 32'h180, 32'h100);
    tally_and_finish();
  end
endmodule : test_hs_counter_zone_table_compare
